/* File: src/sfacd_pkg.sv */
package sfacd_pkg;

   // Instruction bytes
   localparam logic [7:0] OP_READ      = 8'h03;
   localparam logic [7:0] OP_FAST      = 8'h0B;
   localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
   localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
   localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
   localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
   localparam logic [7:0] OP_QUAD_DTR  = 8'hED;
   localparam logic [7:0] OP_PROG      = 8'h02;
   localparam logic [7:0] OP_QPROG     = 8'h38;
   localparam logic [7:0] OP_SMALL_CLR = 8'h20;
   localparam logic [7:0] OP_HALF_CLR  = 8'h52;
   localparam logic [7:0] OP_BLOCK_CLR = 8'hD8;
   localparam logic [7:0] OP_CHIP_A    = 8'h60;
   localparam logic [7:0] OP_CHIP_B    = 8'hC7;
   localparam logic [7:0] OP_QENTRY    = 8'h35;
   localparam logic [7:0] OP_QEXIT     = 8'hF5;

   // Index of the last address byte
   localparam logic [2:0] ADDR_LAST_NARROW = 3'h2;
   localparam logic [2:0] ADDR_LAST_WIDE   = 3'h3;

   // Line counts per transfer phase
   localparam logic [2:0] LANES_1 = 3'h1;
   localparam logic [2:0] LANES_2 = 3'h2;
   localparam logic [2:0] LANES_4 = 3'h4;

   // Dummy cycles selected by {dummy_count_hi, dummy_count_lo}; DUMMY_NONE is used for OP_READ
   localparam logic [4:0] DUMMY_DC0 = 5'h08;
   localparam logic [4:0] DUMMY_DC1 = 5'h06;
   localparam logic [4:0] DUMMY_DC2 = 5'h08;
   localparam logic [4:0] DUMMY_DC3 = 5'h0A;
   localparam logic [4:0] DUMMY_NONE = 5'h00;

   // Reset values
   localparam logic UPPER_BIT_RESET = 1'b0;
   localparam logic QUAD_RESET      = 1'b0;
   localparam logic WIDE_RESET      = 1'b0;

   localparam int PAGE_BYTES_DEFAULT = 256;

   typedef enum logic [1:0] {
      ERASE_SMALL,
      ERASE_HALF,
      ERASE_BLOCK,
      ERASE_CHIP
   } sfacd_erase_type;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CMD,
      ST_ADDR,
      ST_DUMMY,
      ST_DIN,
      ST_DOUT,
      ST_WAIT,
      ST_IGNORE
   } sfacd_state_type;

endpackage

/* File: src/sfacd_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface sfacd_link_if;
   logic       sclk_rise;
   logic       sclk_fall;
   logic       cs_rise;
   logic       cs_fall;
   logic [3:0] io;

   modport src (output sclk_rise, sclk_fall, cs_rise, cs_fall, io);
   modport dst (input  sclk_rise, sclk_fall, cs_rise, cs_fall, io);
endinterface
`default_nettype wire

/* File: src/sfacd_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sfacd_pin_sync (
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Raw pins
   input  wire logic       sclk_in,
   input  wire logic       cs_n_in,
   input  wire logic [3:0] io_in,
   // Synchronised events
   sfacd_link_if.src       link
);
   logic [5:0] meta;
   logic [5:0] sync;
   logic       sclk_d;
   logic       cs_n_d;

   // Two flops before any logic looks at a pin
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         meta <= 6'h20;
         sync <= 6'h20;
      end else begin
         meta <= {cs_n_in, io_in, sclk_in};
         sync <= meta;
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         sclk_d <= 1'b0;
         cs_n_d <= 1'b1;
      end else begin
         sclk_d <= sync[0];
         cs_n_d <= sync[5];
      end
   end

   assign link.sclk_rise = sync[0] & ~sclk_d;
   assign link.sclk_fall = ~sync[0] & sclk_d;
   assign link.cs_fall   = ~sync[5] & cs_n_d;
   assign link.cs_rise   = sync[5] & ~cs_n_d;
   assign link.io        = sync[4:1];
endmodule
`default_nettype wire

/* File: src/sfacd_top.sv */
`timescale 1ns/1ps
`default_nettype none
module sfacd_top #(
   parameter int PAGE_BYTES = sfacd_pkg::PAGE_BYTES_DEFAULT
) (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   // Serial flash pins
   input  wire logic        flash_sclk_in,
   input  wire logic        flash_cs_n_in,
   input  wire logic [3:0]  flash_io_in,
   output logic      [3:0]  flash_io_out,
   output logic      [3:0]  flash_io_oe_out,
   // Configuration
   input  wire logic        dummy_count_lo_in,
   input  wire logic        dummy_count_hi_in,
   input  wire logic        wide_address_entry_in,
   input  wire logic        wide_address_exit_in,
   input  wire logic        upper_addr_wr_in,
   input  wire logic [7:0]  upper_addr_data_in,
   // Array side
   input  wire logic [7:0]  arr_rd_data_in,
   output logic      [31:0] arr_addr_out,
   output logic             arr_rd_req_out,
   output logic             prog_byte_valid_out,
   output logic      [7:0]  prog_byte_out,
   output logic             prog_commit_out,
   output logic      [8:0]  prog_count_out,
   output logic             erase_req_out,
   output logic      [1:0]  erase_kind_out,
   output logic             reject_out,
   // Status
   output logic             quad_mode_out,
   output logic             wide_address_out,
   output logic      [7:0]  upper_address_out
);
   initial begin
      if (PAGE_BYTES < 1 || PAGE_BYTES > 256 || (PAGE_BYTES & (PAGE_BYTES - 1)) != 0)
         $error("PAGE_BYTES must be a power of two up to 256");
   end

   localparam logic [31:0] PAGE_MASK = 32'(PAGE_BYTES - 1);
   localparam logic [8:0]  PAGE_MAX  = 9'(PAGE_BYTES);

   sfacd_link_if link ();

   sfacd_pin_sync u_sync (
      .clk_in  (clk_in),
      .nrst_in (nrst_in),
      .sclk_in (flash_sclk_in),
      .cs_n_in (flash_cs_n_in),
      .io_in   (flash_io_in),
      .link    (link.src)
   );

   sfacd_pkg::sfacd_state_type state;
   sfacd_pkg::sfacd_state_type next_state;
   logic [7:0]  op;
   logic [7:0]  sh;
   logic [2:0]  cnt;
   logic [2:0]  abytes;
   logic [31:0] addr;
   logic [4:0]  dcnt;
   logic [8:0]  pcount;
   logic [7:0]  osh;
   logic [2:0]  ocnt;
   logic        quad_mode;
   logic        wide_mode;
   logic        upper_bit;
   logic [7:0]  byte_in;

   // Decode of the current or arriving instruction byte
   wire [7:0] cmd_byte  = (state == sfacd_pkg::ST_CMD) ? byte_in : op;
   wire op_read  = cmd_byte inside {sfacd_pkg::OP_READ, sfacd_pkg::OP_FAST,
                   sfacd_pkg::OP_DUAL_IO, sfacd_pkg::OP_DUAL_OUT, sfacd_pkg::OP_QUAD_IO,
                   sfacd_pkg::OP_QUAD_OUT, sfacd_pkg::OP_QUAD_DTR};
   wire op_prog  = cmd_byte inside {sfacd_pkg::OP_PROG, sfacd_pkg::OP_QPROG};
   wire op_erase = cmd_byte inside {sfacd_pkg::OP_SMALL_CLR, sfacd_pkg::OP_HALF_CLR,
                   sfacd_pkg::OP_BLOCK_CLR};
   wire op_chip  = cmd_byte inside {sfacd_pkg::OP_CHIP_A, sfacd_pkg::OP_CHIP_B};
   wire op_qentry = cmd_byte == sfacd_pkg::OP_QENTRY;
   wire op_qexit  = cmd_byte == sfacd_pkg::OP_QEXIT;
   wire quad_ok  = cmd_byte inside {sfacd_pkg::OP_QUAD_IO, sfacd_pkg::OP_QUAD_DTR,
                   sfacd_pkg::OP_PROG} | op_erase | op_chip | op_qexit;
   wire single_ok = op_read | op_prog | op_erase | op_chip | op_qentry;
   wire cmd_ok   = quad_mode ? quad_ok : single_ok;

   // Line counts per phase
   wire [2:0] cmd_lanes  = quad_mode ? sfacd_pkg::LANES_4 : sfacd_pkg::LANES_1;
   wire quad_addr = quad_mode | (op inside {sfacd_pkg::OP_QUAD_IO, sfacd_pkg::OP_QUAD_DTR,
                    sfacd_pkg::OP_QPROG});
   wire [2:0] addr_lanes = quad_addr ? sfacd_pkg::LANES_4 :
                           (op == sfacd_pkg::OP_DUAL_IO) ? sfacd_pkg::LANES_2 :
                           sfacd_pkg::LANES_1;
   wire [2:0] din_lanes  = (quad_mode | (op == sfacd_pkg::OP_QPROG)) ? sfacd_pkg::LANES_4 :
                           sfacd_pkg::LANES_1;
   wire [2:0] dout_lanes = (op inside {sfacd_pkg::OP_READ, sfacd_pkg::OP_FAST}) ?
                           sfacd_pkg::LANES_1 :
                           (op inside {sfacd_pkg::OP_DUAL_IO, sfacd_pkg::OP_DUAL_OUT}) ?
                           sfacd_pkg::LANES_2 : sfacd_pkg::LANES_4;
   wire [2:0] rx_lanes   = (state == sfacd_pkg::ST_ADDR) ? addr_lanes :
                           (state == sfacd_pkg::ST_DIN) ? din_lanes : cmd_lanes;

   // Receive shifter
   assign byte_in = (rx_lanes == sfacd_pkg::LANES_4) ? {sh[3:0], link.io} :
                        (rx_lanes == sfacd_pkg::LANES_2) ? {sh[5:0], link.io[1:0]} :
                        {sh[6:0], link.io[0]};
   wire [3:0] cnt_sum   = {1'b0, cnt} + {1'b0, rx_lanes};
   wire       byte_done = link.sclk_rise & cnt_sum[3];
   wire [2:0] addr_last = wide_mode ? sfacd_pkg::ADDR_LAST_WIDE :
                          sfacd_pkg::ADDR_LAST_NARROW;
   wire       addr_done = (state == sfacd_pkg::ST_ADDR) & byte_done & (abytes == addr_last);
   wire [31:0] addr_full = wide_mode ? {addr[23:0], byte_in} :
                           {7'h00, upper_bit, addr[15:0], byte_in};

   // Dummy count selection
   wire [4:0] dummy_sel = {dummy_count_hi_in, dummy_count_lo_in} == 2'h0 ? sfacd_pkg::DUMMY_DC0 :
                          {dummy_count_hi_in, dummy_count_lo_in} == 2'h1 ? sfacd_pkg::DUMMY_DC1 :
                          {dummy_count_hi_in, dummy_count_lo_in} == 2'h2 ? sfacd_pkg::DUMMY_DC2 :
                          sfacd_pkg::DUMMY_DC3;
   wire [4:0] dummy_target = (op == sfacd_pkg::OP_READ) ? sfacd_pkg::DUMMY_NONE :
                             dummy_sel;
   wire [4:0] dcnt_inc = dcnt + 5'h01;

   // Transmit path
   wire [7:0] tx_now   = (ocnt == 3'h0) ? arr_rd_data_in : osh;
   wire [3:0] cnt_osum = {1'b0, ocnt} + {1'b0, dout_lanes};
   wire [3:0] tx_bits  = (dout_lanes == sfacd_pkg::LANES_4) ? tx_now[7:4] :
                         (dout_lanes == sfacd_pkg::LANES_2) ? {2'h0, tx_now[7:6]} :
                         {2'h0, tx_now[7], 1'b0};
   wire [3:0] tx_oe    = (dout_lanes == sfacd_pkg::LANES_4) ? 4'hF :
                         (dout_lanes == sfacd_pkg::LANES_2) ? 4'h3 : 4'h2;
   wire tx_step = (state == sfacd_pkg::ST_DOUT) & link.sclk_fall;

   // Execution at chip select rise
   wire aligned  = cnt == 3'h0;
   wire exec_ok  = link.cs_rise & aligned & ((state == sfacd_pkg::ST_WAIT) |
                   ((state == sfacd_pkg::ST_DIN) & (pcount != 9'h000)));
   wire writeish = (state inside {sfacd_pkg::ST_ADDR, sfacd_pkg::ST_WAIT, sfacd_pkg::ST_DIN})
                   & ~op_read;
   wire din_byte = (state == sfacd_pkg::ST_DIN) & byte_done;
   wire [31:0] page_next = (addr & ~PAGE_MASK) | ((addr + 32'h1) & PAGE_MASK);
   wire [1:0] erase_kind = (op == sfacd_pkg::OP_SMALL_CLR) ? sfacd_pkg::ERASE_SMALL :
                           (op == sfacd_pkg::OP_HALF_CLR) ? sfacd_pkg::ERASE_HALF :
                           (op == sfacd_pkg::OP_BLOCK_CLR) ? sfacd_pkg::ERASE_BLOCK :
                           sfacd_pkg::ERASE_CHIP;

   always_comb begin
      next_state = state;
      if (link.cs_fall) begin
         next_state = sfacd_pkg::ST_CMD;
      end else if (link.cs_rise) begin
         next_state = sfacd_pkg::ST_IDLE;
      end else if (link.sclk_rise) begin
         unique case (state)
            sfacd_pkg::ST_CMD: begin
               if (byte_done) begin
                  if (!cmd_ok)
                     next_state = sfacd_pkg::ST_IGNORE;
                  else if (op_read | op_prog | op_erase)
                     next_state = sfacd_pkg::ST_ADDR;
                  else
                     next_state = sfacd_pkg::ST_WAIT;
               end
            end
            sfacd_pkg::ST_ADDR: begin
               if (addr_done) begin
                  if (op_read)
                     next_state = (dummy_target == sfacd_pkg::DUMMY_NONE) ?
                                  sfacd_pkg::ST_DOUT : sfacd_pkg::ST_DUMMY;
                  else if (op_prog)
                     next_state = sfacd_pkg::ST_DIN;
                  else
                     next_state = sfacd_pkg::ST_WAIT;
               end
            end
            sfacd_pkg::ST_DUMMY: begin
               if (dcnt_inc == dummy_target)
                  next_state = sfacd_pkg::ST_DOUT;
            end
            sfacd_pkg::ST_IDLE, sfacd_pkg::ST_DIN, sfacd_pkg::ST_DOUT,
            sfacd_pkg::ST_WAIT, sfacd_pkg::ST_IGNORE: begin
               next_state = state;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= sfacd_pkg::ST_IDLE;
         sh    <= 8'h00;
         op    <= 8'h00;
      end else begin
         state <= next_state;
         sh    <= link.sclk_rise ? byte_in : sh;
         if ((state == sfacd_pkg::ST_CMD) && byte_done)
            op <= byte_in;
      end
   end

   // Bit, byte and dummy counters
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt    <= 3'h0;
         abytes <= 3'h0;
         dcnt   <= 5'h00;
         pcount <= 9'h000;
      end else if (link.cs_fall) begin
         cnt    <= 3'h0;
         abytes <= 3'h0;
         dcnt   <= 5'h00;
         pcount <= 9'h000;
      end else if (link.sclk_rise && state != sfacd_pkg::ST_IDLE) begin
         cnt <= cnt_sum[2:0];
         if ((state == sfacd_pkg::ST_ADDR) && byte_done)
            abytes <= abytes + 3'h1;
         if (state == sfacd_pkg::ST_DUMMY)
            dcnt <= dcnt_inc;
         if (din_byte && pcount != PAGE_MAX)
            pcount <= pcount + 9'h001;
      end
   end

   // Address register, page wrap while programming, advance while reading
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in)
         addr <= 32'h0000_0000;
      else if (addr_done)
         addr <= addr_full;
      else if ((state == sfacd_pkg::ST_ADDR) && byte_done)
         addr <= {addr[23:0], byte_in};
      else if (din_byte)
         addr <= page_next;
      else if (tx_step && cnt_osum[3])
         addr <= addr + 32'h1;
   end

   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         osh             <= 8'h00;
         ocnt            <= 3'h0;
         flash_io_out    <= 4'h0;
         flash_io_oe_out <= 4'h0;
      end else if (link.cs_rise || link.cs_fall) begin
         ocnt            <= 3'h0;
         flash_io_oe_out <= 4'h0;
      end else if (tx_step) begin
         osh             <= tx_now << dout_lanes;
         ocnt            <= cnt_osum[2:0];
         flash_io_out    <= tx_bits;
         flash_io_oe_out <= tx_oe;
      end
   end

   // Array requests and command execution
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         arr_rd_req_out      <= 1'b0;
         prog_byte_valid_out <= 1'b0;
         prog_byte_out       <= 8'h00;
         prog_commit_out     <= 1'b0;
         erase_req_out       <= 1'b0;
         erase_kind_out      <= 2'h0;
         reject_out          <= 1'b0;
      end else begin
         arr_rd_req_out      <= (addr_done & op_read) | (tx_step & cnt_osum[3]);
         prog_byte_valid_out <= din_byte;
         prog_byte_out       <= din_byte ? byte_in : prog_byte_out;
         prog_commit_out     <= exec_ok & op_prog;
         erase_req_out       <= exec_ok & (op_erase | op_chip);
         erase_kind_out      <= erase_kind;
         reject_out          <= link.cs_rise & writeish & ~exec_ok;
      end
   end

   // Mode flags and upper address register
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         quad_mode <= sfacd_pkg::QUAD_RESET;
         wide_mode <= sfacd_pkg::WIDE_RESET;
         upper_bit <= sfacd_pkg::UPPER_BIT_RESET;
      end else begin
         if (exec_ok && op_qentry)
            quad_mode <= 1'b1;
         else if (exec_ok && op_qexit)
            quad_mode <= 1'b0;
         if (wide_address_entry_in)
            wide_mode <= 1'b1;
         else if (wide_address_exit_in)
            wide_mode <= 1'b0;
         if (upper_addr_wr_in)
            upper_bit <= upper_addr_data_in[0];
      end
   end

   assign arr_addr_out      = addr;
   assign prog_count_out    = pcount;
   assign quad_mode_out     = quad_mode;
   assign wide_address_out  = wide_mode;
   assign upper_address_out = {7'h00, upper_bit};

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   quad_exit_a: assert property (exec_ok && op_qexit |=> !quad_mode)
      else $error("quad exit did not leave four-line mode");
   single_cmd_a: assert property (!quad_mode && state == sfacd_pkg::ST_CMD
      |-> rx_lanes == sfacd_pkg::LANES_1)
      else $error("single-line command taken on several lines");
   read_stream_a: assert property (tx_step && cnt_osum[3] |=> arr_rd_req_out)
      else $error("read stream did not fetch the next byte");
   chip_noaddr_a: assert property (state == sfacd_pkg::ST_CMD && byte_done && cmd_ok
      && op_chip && !link.cs_rise && !link.cs_fall |=> state == sfacd_pkg::ST_WAIT)
      else $error("chip erase expected address bytes");
   prog_len_a: assert property (prog_commit_out
      |-> prog_count_out >= 9'h001 && prog_count_out <= PAGE_MAX)
      else $error("program committed with bad byte count");
   dummy_len_a: assert property ($past(state) == sfacd_pkg::ST_DUMMY
      && state == sfacd_pkg::ST_DOUT |-> dcnt == dummy_target)
      else $error("dummy count does not match configuration");
   addr_three_a: assert property (addr_done && !wide_mode |-> abytes == 3'h2)
      else $error("narrow address not three bytes");
   addr_four_a: assert property (addr_done && wide_mode |-> abytes == 3'h3)
      else $error("wide address not four bytes");
   quad_entry_a: assert property (exec_ok && op_qentry |=> quad_mode ##1 quad_mode)
      else $error("quad entry did not take effect");
   commit_align_a: assert property (prog_commit_out || erase_req_out
      || $changed(quad_mode) |-> $past(cnt) == 3'h0 && $past(link.cs_rise))
      else $error("execution off a byte boundary");
   upper_map_a: assert property ($past(addr_done) && !$past(wide_mode)
      |-> arr_addr_out[31:25] == 7'h00 && arr_addr_out[24] == $past(upper_bit))
      else $error("upper address bits mapped wrongly");

   quad_read_c: cover property (state == sfacd_pkg::ST_DOUT && dout_lanes == sfacd_pkg::LANES_4);
   prog_commit_c: cover property (prog_commit_out);
   quad_exit_c: cover property ($fell(quad_mode));
   reject_c: cover property (reject_out);
endmodule
`default_nettype wire

/* File: tb/sfacd_host.sv */
`timescale 1ns/1ps
`default_nettype none
module sfacd_host (
   // Clock
   input  wire logic       clk_in,
   // Flash pins
   output logic            sclk_out,
   output logic            cs_n_out,
   output logic      [3:0] io_out,
   input  wire logic [3:0] io_in
);
   localparam int HALF = 6;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      io_out   = 4'hA;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask
   task automatic start();
      @(posedge clk_in);
      cs_n_out <= 1'b0;
      tick(HALF);
   endtask
   // MSB first, higher bit on the higher lane
   task automatic send(input logic [31:0] v, input int bits, input int lanes);
      for (int i = bits - lanes; i >= 0; i -= lanes) begin
         sclk_out <= 1'b0;
         io_out   <= (lanes == 1) ? {3'h0, v[i]} : (lanes == 2) ? {2'h0, v[i+:2]} : v[i+:4];
         tick(HALF);
         sclk_out <= 1'b1;
         tick(HALF);
      end
      io_out <= ~io_out;
      tick(1);
   endtask
   // Single-line data comes back on io1
   task automatic recv(output logic [7:0] v, input int lanes);
      for (int i = 0; i < 8; i += lanes) begin
         sclk_out <= 1'b0;
         tick(HALF);
         v = (lanes == 1) ? {v[6:0], io_in[1]} :
             (lanes == 2) ? {v[5:0], io_in[1:0]} : {v[3:0], io_in};
         sclk_out <= 1'b1;
         tick(HALF);
      end
   endtask
   task automatic stop();
      cs_n_out <= 1'b1;
      tick(HALF);
      sclk_out <= 1'b0;
      tick(HALF);
   endtask
endmodule
`default_nettype wire

/* File: tb/test_sfacd.sv */
`timescale 1ns/1ps
`default_nettype none
module test_sfacd;
   typedef struct {logic [7:0] op; int al; bit dm; int dl; logic [1:0] ek; logic [1:0] cfg;}
      sfacd_row_type;
   localparam logic [31:0] ADDR = 32'h001234F0;
   logic clk_in = 1'b0, nrst_in, sclk, cs_n, wide_in, wexit_in;
   logic up_wr, dc_lo, dc_hi, quad_out, wide_out, rej, commit, ereq;
   logic [7:0] up_data, rd_data, up_out, b0, b1, pbyte;
   logic [15:0] prog_seen;
   logic [3:0] host_io, io_out, io_oe;
   logic [31:0] addr;
   logic [8:0] pcount, count_seen;
   logic [1:0] ekind, kind_seen;
   logic pvalid, rd_req;
   int error_cnt = 0, comparisons = 0, erase_cnt = 0, commit_cnt = 0, reject_cnt = 0, n;
   int rd_cnt = 0, m;
   sfacd_row_type rows [12] = '{
      '{8'h03,1,0,1,0,0}, '{8'h0B,1,1,1,0,1}, '{8'hBB,2,1,2,0,2}, '{8'h3B,1,1,2,0,3},
      '{8'hEB,4,1,4,0,0}, '{8'h6B,1,1,4,0,1}, '{8'hED,4,1,4,0,3}, '{8'h20,1,0,0,0,0},
      '{8'h52,1,0,0,1,0}, '{8'hD8,1,0,0,2,0}, '{8'h60,0,0,0,3,0}, '{8'hC7,0,0,0,3,0}};
   always #2 clk_in = ~clk_in;
   sfacd_host i_host (.clk_in(clk_in), .sclk_out(sclk), .cs_n_out(cs_n), .io_out(host_io),
      .io_in(io_out));
   sfacd_top i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .flash_sclk_in(sclk),
      .flash_cs_n_in(cs_n), .flash_io_in((io_oe & io_out) | (~io_oe & host_io)),
      .flash_io_out(io_out), .flash_io_oe_out(io_oe), .dummy_count_lo_in(dc_lo),
      .dummy_count_hi_in(dc_hi), .wide_address_entry_in(wide_in),
      .wide_address_exit_in(wexit_in), .upper_addr_wr_in(up_wr), .upper_addr_data_in(up_data),
      .arr_rd_data_in(rd_data), .arr_addr_out(addr), .arr_rd_req_out(rd_req),
      .prog_byte_valid_out(pvalid), .prog_byte_out(pbyte), .prog_commit_out(commit),
      .prog_count_out(pcount), .erase_req_out(ereq), .erase_kind_out(ekind),
      .reject_out(rej), .quad_mode_out(quad_out), .wide_address_out(wide_out),
      .upper_address_out(up_out));
   // Array content and pulse counters
   always @(posedge clk_in) begin
      rd_data <= addr[31:24] ^ addr[15:8] ^ addr[7:0];
      if (ereq === 1'b1) begin erase_cnt++; kind_seen <= ekind; end
      if (commit === 1'b1) begin commit_cnt++; count_seen <= pcount; end
      if (rej === 1'b1) reject_cnt++;
      if (rd_req === 1'b1) rd_cnt++;
      if (pvalid === 1'b1) prog_seen <= {prog_seen[7:0], pbyte};
   end
   function automatic logic [7:0] xb(input logic [31:0] a);
      return a[31:24] ^ a[15:8] ^ a[7:0];
   endfunction
   function automatic int dummies(input logic [1:0] c);
      logic [4:0] t [4] = '{sfacd_pkg::DUMMY_DC0, sfacd_pkg::DUMMY_DC1,
                            sfacd_pkg::DUMMY_DC2, sfacd_pkg::DUMMY_DC3};
      return int'(t[c]);
   endfunction
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic frame(input logic [7:0] op, input int ol, input int al, input int ab,
                        input logic [31:0] a, input bit dm, input int dl);
      i_host.start();
      i_host.send({24'h0, op}, 8, ol);
      if (al != 0) i_host.send(a, ab * 8, al);
      if (dm) i_host.send(32'h0, dummies({dc_hi, dc_lo}), 1);
      if (dl != 0) begin
         i_host.recv(b0, dl);
         i_host.recv(b1, dl);
      end
      i_host.stop();
   endtask
   task automatic conclude();
      $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      conclude();
   end
   initial begin
      nrst_in <= 1'b0;
      wide_in <= 1'b0;
      wexit_in <= 1'b0;
      up_wr <= 1'b0;
      up_data <= 8'h00;
      dc_lo <= 1'b0;
      dc_hi <= 1'b0;
      prog_seen <= 16'h0000;
      repeat (3) @(posedge clk_in);
      nrst_in <= 1'b1;
      i_host.tick(4);
      check("status", 32'h0, {quad_out, wide_out, up_out});
      up_wr <= 1'b1;
      up_data <= 8'hFF;
      i_host.tick(1);
      up_wr <= 1'b0;
      i_host.tick(1);
      check("upper", 32'h1, up_out);
      for (int r = 0; r < 12; r++) begin
         dc_hi <= rows[r].cfg[1];
         dc_lo <= rows[r].cfg[0];
         n = erase_cnt;
         m = rd_cnt;
         frame(rows[r].op, 1, rows[r].al, 3, ADDR, rows[r].dm, rows[r].dl);
         if (rows[r].dl != 0) begin
            check("read byte 0", xb(ADDR | 32'h01000000), b0);
            check("read byte 1", xb(ADDR | 32'h01000001), b1);
            check("read requests", m + 3, rd_cnt);
            check("drive release", 32'h0, io_oe);
         end else begin
            check("erase count", n + 1, erase_cnt);
            check("erase kind", rows[r].ek, kind_seen);
         end
      end
      n = commit_cnt;
      i_host.start();
      i_host.send(32'h02, 8, 1);
      i_host.send(ADDR, 24, 1);
      i_host.send(32'hA55A, 16, 1);
      i_host.stop();
      check("commit count", n + 1, commit_cnt);
      check("program bytes", 32'h2, count_seen);
      check("program data", 32'hA55A, prog_seen);
      check("program address", 32'h011234F2, addr);
      i_host.start();
      i_host.send(32'h38, 8, 1);
      i_host.send(ADDR, 24, 4);
      i_host.send(32'hC33C, 16, 4);
      i_host.stop();
      check("quad program count", n + 2, commit_cnt);
      check("quad program data", 32'hC33C, prog_seen);
      n = reject_cnt;
      i_host.start();
      i_host.send(32'h02, 8, 1);
      i_host.send(ADDR, 24, 1);
      i_host.send(32'h5A5, 11, 1);
      i_host.stop();
      check("reject", n + 1, reject_cnt);
      frame(8'h35, 1, 0, 0, 0, 0, 0);
      check("quad entry", 32'h1, quad_out);
      n = reject_cnt;
      frame(8'h0B, 4, 0, 0, 0, 0, 0);
      check("refused in quad", n, reject_cnt);
      check("refused drive", 32'h0, io_oe);
      frame(8'hEB, 4, 4, 3, ADDR, 1, 4);
      check("quad read", xb(ADDR | 32'h01000000), b0);
      frame(8'hF5, 4, 0, 0, 0, 0, 0);
      check("quad exit", 32'h0, quad_out);
      n = erase_cnt;
      frame(8'h20, 1, 1, 3, ADDR, 0, 0);
      check("single line erase", n + 1, erase_cnt);
      wide_in <= 1'b1;
      i_host.tick(1);
      wide_in <= 1'b0;
      i_host.tick(1);
      check("wide", 32'h1, wide_out);
      frame(8'h03, 1, 1, 4, 32'h03000010, 0, 1);
      check("wide read", xb(32'h03000010), b0);
      wexit_in <= 1'b1;
      i_host.tick(1);
      wexit_in <= 1'b0;
      i_host.tick(1);
      check("narrow", 32'h0, wide_out);
      conclude();
   end
endmodule
`default_nettype wire
